// ==== design/pmm_phy_end.sv ====
// Purpose: transceiver side of the nibble data port and management target
// Assumes: i_clk 125 MHz; straps steady around reset release
// Notes: line clocks are divided from i_clk, so no second domain here
`timescale 1ns/1ns
module pmm_phy_end (
  // system
  input wire logic i_clk,
  input wire logic i_reset_n,
  // straps
  input wire logic [3:0] i_mode_straps,
  input wire logic i_ref_clock_out_enable_strap,
  input wire logic [2:0] i_mgmt_address_straps,
  // line status
  input wire logic i_speed_100,
  input wire logic i_full_duplex,
  input wire logic i_carrier,
  input wire logic i_collision,
  // receive nibbles from the line
  input wire logic i_rx_dv,
  input wire logic [3:0] i_rx_nibble,
  input wire logic i_rx_err,
  output logic o_rx_take,
  // transmit nibbles to the line
  output logic o_tx_strobe,
  output logic o_tx_en,
  output logic [3:0] o_tx_nibble,
  output logic o_tx_err,
  // register access
  output logic o_mgmt_wr,
  output logic o_mgmt_rd,
  output logic [4:0] o_mgmt_reg,
  output logic [15:0] o_mgmt_wdata,
  input wire logic [15:0] i_mgmt_rdata,
  // strap results
  output logic o_mii_mode,
  output logic [2:0] o_mgmt_addr,
  // pins
  pmm_mii_if.phy link
);

  // ==========================================================
  // line clock dividers, index 0 transmit, 1 receive
  function automatic logic [5:0] div_top(input logic fast);
    div_top = fast ? 6'(pmm_pkg::FAST_DIV) : 6'(pmm_pkg::SLOW_DIV);
  endfunction : div_top

  logic [1:0] lclk;
  logic [1:0] lfall;

  for (genvar g = 0; g < 2; g++) begin : g_div
    logic [5:0] cnt_reg;
    logic [5:0] cnt_next;
    logic clk_reg;
    logic clk_next;
    logic [5:0] top;
    always_comb begin
      top = div_top(i_speed_100); // R7
      if (cnt_reg >= top - 6'd1) begin
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 6'd1;
      end
      // phase follows the count one edge late, so the reset state is a true low phase
      clk_next = cnt_reg < (top >> 1); // R1 R2
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
        cnt_reg <= '0;
        clk_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_next;
        clk_reg <= clk_next;
      end
    end
    assign lclk[g] = clk_reg;
    assign lfall[g] = !clk_reg && (cnt_reg == (top >> 1) + 6'd1);
  end

  assign link.tx_clk = lclk[0]; // R1 R8
  assign link.rx_clk = lclk[1]; // R2 R8

  // ==========================================================
  // straps, caught on the first edge after reset release
  logic strap_done_reg;
  logic strap_done_next;
  logic mii_mode_reg;
  logic mii_mode_next;
  logic refclk_en_reg;
  logic refclk_en_next;
  logic [2:0] addr_reg;
  logic [2:0] addr_next;

  always_comb begin
    strap_done_next = 1'b1;
    mii_mode_next = mii_mode_reg;
    refclk_en_next = refclk_en_reg;
    addr_next = addr_reg;
    if (!strap_done_reg) begin
      mii_mode_next = i_mode_straps == pmm_pkg::MODE_NIBBLE_GIG; // R9
      refclk_en_next = i_ref_clock_out_enable_strap; // R10
      addr_next = i_mgmt_address_straps; // R12
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      strap_done_reg <= 1'b0;
      mii_mode_reg <= 1'b0;
      refclk_en_reg <= 1'b0;
      addr_reg <= '0;
    end else begin
      strap_done_reg <= strap_done_next;
      mii_mode_reg <= mii_mode_next;
      refclk_en_reg <= refclk_en_next;
      addr_reg <= addr_next;
    end
  end

  assign o_mii_mode = mii_mode_reg;
  assign o_mgmt_addr = addr_reg;
  // gated system clock; the enable only changes once, just after reset
  assign link.ref_clock_out_pin = i_clk & refclk_en_reg; // R10

  // ==========================================================
  // pin synchronisers: tx group, mdc, mdio
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic mdc_prev_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      mdc_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.mdio, link.mdc, link.tx_er, link.tx_en, link.txd}; // R3
      sync2_reg <= sync1_reg;
      mdc_prev_reg <= sync2_reg[6];
    end
  end

  // ==========================================================
  // data path; sampling at our own falling edge leaves margin for the
  // MAC's synchroniser delay at 25 MHz
  logic tx_en_reg;
  logic tx_en_next;
  logic [3:0] tx_nib_reg;
  logic [3:0] tx_nib_next;
  logic tx_err_reg;
  logic tx_err_next;
  logic [5:0] rx_pins_reg;
  logic [5:0] rx_pins_next;
  logic crs_reg;
  logic crs_next;
  logic col_reg;
  logic col_next;

  always_comb begin
    tx_en_next = tx_en_reg;
    tx_nib_next = tx_nib_reg;
    tx_err_next = tx_err_reg;
    rx_pins_next = rx_pins_reg;
    if (lfall[0]) begin
      tx_en_next = sync2_reg[4]; // R6
      tx_nib_next = sync2_reg[3:0];
      tx_err_next = sync2_reg[5];
    end
    if (lfall[1]) begin
      rx_pins_next = {i_rx_err, i_rx_dv, i_rx_nibble}; // R4 R6
    end
    crs_next = i_carrier | (!i_full_duplex & tx_en_reg); // R5 R7
    col_next = !i_full_duplex & i_collision; // R5 R7
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_en_reg <= 1'b0;
      tx_nib_reg <= '0;
      tx_err_reg <= 1'b0;
      rx_pins_reg <= '0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      tx_en_reg <= tx_en_next;
      tx_nib_reg <= tx_nib_next;
      tx_err_reg <= tx_err_next;
      rx_pins_reg <= rx_pins_next;
      crs_reg <= crs_next;
      col_reg <= col_next;
    end
  end

  assign o_tx_en = tx_en_reg;
  assign o_tx_nibble = tx_nib_reg;
  assign o_tx_err = tx_err_reg;
  assign o_tx_strobe = lfall[0] && sync2_reg[4];
  assign o_rx_take = lfall[1];
  assign link.rxd = rx_pins_reg[3:0];
  assign link.rx_dv = rx_pins_reg[4];
  assign link.rx_er = rx_pins_reg[5];
  assign link.crs = crs_reg;
  assign link.col = col_reg;

  // ==========================================================
  // management target
  pmm_pkg::pmm_tgt_state_t st_reg;
  pmm_pkg::pmm_tgt_state_t st_next;
  logic [5:0] ones_reg;
  logic [5:0] ones_next;
  logic [11:0] hdr_reg;
  logic [11:0] hdr_next;
  logic [4:0] bit_reg;
  logic [4:0] bit_next;
  logic [15:0] sh_reg;
  logic [15:0] sh_next;
  logic mdo_reg;
  logic mdo_next;
  logic mdoe_reg;
  logic mdoe_next;
  logic wr_reg;
  logic wr_next;
  logic rd_reg;
  logic rd_next;
  logic [4:0] reg_reg;
  logic [4:0] reg_next;
  logic [15:0] wdata_reg;
  logic [15:0] wdata_next;
  logic mrise;
  logic mbit;
  logic [11:0] hdr_full;

  assign mrise = sync2_reg[6] && !mdc_prev_reg;
  assign mbit = sync2_reg[7];
  assign hdr_full = {hdr_reg[10:0], mbit};

  always_comb begin
    st_next = st_reg;
    ones_next = ones_reg;
    hdr_next = hdr_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    mdo_next = mdo_reg;
    mdoe_next = mdoe_reg;
    reg_next = reg_reg;
    wdata_next = wdata_reg;
    wr_next = 1'b0;
    rd_next = 1'b0;
    if (mrise) begin
      case (st_reg)
        pmm_pkg::MS_PRE: begin
          if (mbit) begin
            if (ones_reg < 6'(pmm_pkg::PREAMBLE_ONES)) begin
              ones_next = ones_reg + 6'd1;
            end
          end else begin
            if (ones_reg == 6'(pmm_pkg::PREAMBLE_ONES)) begin // R15
              st_next = pmm_pkg::MS_START;
            end
            ones_next = '0;
          end
        end
        pmm_pkg::MS_START: begin
          st_next = mbit ? pmm_pkg::MS_HDR : pmm_pkg::MS_PRE; // R15
          bit_next = '0;
        end
        pmm_pkg::MS_HDR: begin
          hdr_next = hdr_full;
          bit_next = bit_reg + 5'd1;
          if (bit_reg == 5'(pmm_pkg::HDR_BITS - 1)) begin
            bit_next = '0;
            st_next = pmm_pkg::MS_PRE;
            reg_next = hdr_full[4:0]; // R14
            // exact match only, zero is not a broadcast
            if (hdr_full[9:5] == {pmm_pkg::ADDR_HIGH, addr_reg}) begin // R12 R13
              if (hdr_full[11:10] == pmm_pkg::OP_READ) begin
                st_next = pmm_pkg::MS_TA;
              end else if (hdr_full[11:10] == pmm_pkg::OP_WRITE) begin
                st_next = pmm_pkg::MS_WR;
              end
            end
          end
        end
        pmm_pkg::MS_TA: begin
          mdoe_next = 1'b1; // R11 R16
          mdo_next = 1'b0;
          sh_next = i_mgmt_rdata;
          rd_next = 1'b1;
          bit_next = '0;
          st_next = pmm_pkg::MS_RD;
        end
        pmm_pkg::MS_RD: begin
          if (bit_reg == 5'(pmm_pkg::DATA_BITS)) begin
            mdoe_next = 1'b0; // R16
            st_next = pmm_pkg::MS_PRE;
          end else begin
            mdo_next = sh_reg[15]; // R16
            sh_next = {sh_reg[14:0], 1'b0};
            bit_next = bit_reg + 5'd1;
          end
        end
        pmm_pkg::MS_WR: begin
          sh_next = {sh_reg[14:0], mbit};
          bit_next = bit_reg + 5'd1;
          if (bit_reg == 5'(pmm_pkg::DATA_BITS + 1)) begin // R16
            wr_next = 1'b1;
            wdata_next = {sh_reg[14:0], mbit};
            st_next = pmm_pkg::MS_PRE;
          end
        end
        default: begin
          st_next = pmm_pkg::MS_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= pmm_pkg::MS_PRE;
      ones_reg <= '0;
      hdr_reg <= '0;
      bit_reg <= '0;
      sh_reg <= '0;
      mdo_reg <= 1'b1;
      mdoe_reg <= 1'b0;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      reg_reg <= '0;
      wdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      ones_reg <= ones_next;
      hdr_reg <= hdr_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      mdo_reg <= mdo_next;
      mdoe_reg <= mdoe_next;
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      reg_reg <= reg_next;
      wdata_reg <= wdata_next;
    end
  end

  assign link.mdio_phy_o = mdo_reg;
  assign link.mdio_phy_oe = mdoe_reg;
  assign o_mgmt_wr = wr_reg;
  assign o_mgmt_rd = rd_reg;
  assign o_mgmt_reg = reg_reg;
  assign o_mgmt_wdata = wdata_reg;

endmodule : pmm_phy_end

// ==== design/pmm_pkg.sv ====
// Purpose: shared constants and types for the nibble data port and its serial management port
// Assumes: both ends run on a 125 MHz system clock
// Notes: Operation list below
// Operation
// R1: device makes transmit clock, 25 or 2.5 MHz
// R2: device makes receive clock, 25 or 2.5 MHz
// R3: MAC changes transmit group with transmit clock
// R4: device changes receive group with receive clock
// R5: carrier and collision are asynchronous to MAC
// R6: one four-bit nibble per clock each way
// R7: 10 and 100 Mbps, half and full duplex
// R8: transmit and receive paths fully independent
// R9: latch mode straps at reset; 0001 selects mode
// R10: 125 MHz output only when strap high
// R11: controller drives clock; shared one-wire data line
// R12: respond only when address field matches straps
// R13: address zero is never a broadcast
// R14: five-bit register field, 32 16-bit registers
// R15: frame: 32 ones, 01, opcode, 00AAA, register
// R16: read turnaround released then 0; write 10
package pmm_pkg;

  // ==========================================================
  // clocking
  localparam int SYS_CLK_KHZ = 125000;
  localparam int SYS_CLK_NS = 8;
  localparam int MII_FAST_KHZ = 25000;
  localparam int MII_SLOW_KHZ = 2500;
  localparam int FAST_DIV = SYS_CLK_KHZ / MII_FAST_KHZ;
  localparam int SLOW_DIV = SYS_CLK_KHZ / MII_SLOW_KHZ;
  localparam int DIV_W = 6;
  // management clock period, least time, so half period rounds up
  localparam int MDC_PERIOD_NS = 400;
  localparam int MDC_HALF_CYC = (MDC_PERIOD_NS + 2 * SYS_CLK_NS - 1) / (2 * SYS_CLK_NS);

  // ==========================================================
  // straps
  localparam logic [3:0] MODE_NIBBLE_GIG = 4'h1;

  // ==========================================================
  // management frame
  localparam int PREAMBLE_ONES = 32;
  localparam int HDR_BITS = 12;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = 64;
  localparam int TA_FIRST_IDX = 46;
  localparam int DATA_FIRST_IDX = 48;
  localparam logic [1:0] START_PAT = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] ADDR_HIGH = 2'h0;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [31:0] PREAMBLE = 32'hFFFF_FFFF;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    MS_PRE,
    MS_START,
    MS_HDR,
    MS_TA,
    MS_RD,
    MS_WR
  } pmm_tgt_state_t;

  typedef enum logic {
    HS_IDLE,
    HS_RUN
  } pmm_ctl_state_t;

endpackage : pmm_pkg

// ==== design/pmm_mii_if.sv ====
// Purpose: pins between the transceiver end and the MAC end
// Assumes: management data line has a pull-up
// Notes: the line is the AND of both released-high drivers
`timescale 1ns/1ns
interface pmm_mii_if;
  logic tx_clk;
  logic tx_en;
  logic [3:0] txd;
  logic tx_er;
  logic rx_clk;
  logic rx_dv;
  logic [3:0] rxd;
  logic rx_er;
  logic crs;
  logic col;
  logic ref_clock_out_pin;
  logic mdc;
  logic mdio_phy_o;
  logic mdio_phy_oe;
  logic mdio_mac_o;
  logic mdio_mac_oe;
  logic mdio;

  // pull-up when nobody drives
  assign mdio = (mdio_phy_oe ? mdio_phy_o : 1'b1) & (mdio_mac_oe ? mdio_mac_o : 1'b1);

  modport phy (
    output tx_clk, rx_clk, rx_dv, rxd, rx_er, crs, col, ref_clock_out_pin,
    output mdio_phy_o, mdio_phy_oe,
    input tx_en, txd, tx_er, mdc, mdio
  );

  modport mac (
    input tx_clk, rx_clk, rx_dv, rxd, rx_er, crs, col, ref_clock_out_pin,
    input mdio,
    output tx_en, txd, tx_er, mdc, mdio_mac_o, mdio_mac_oe
  );
endinterface : pmm_mii_if

// ==== design/pmm_mac_end.sv ====
// Purpose: MAC side of the nibble data port and management controller
// Assumes: i_clk 125 MHz; line clocks come from the transceiver
// Notes: line clocks are sampled, not used as clocks
`timescale 1ns/1ns
module pmm_mac_end (
  // system
  input wire logic i_clk,
  input wire logic i_reset_n,
  // transmit nibbles
  input wire logic i_tx_valid,
  input wire logic [3:0] i_tx_nibble,
  input wire logic i_tx_err,
  output logic o_tx_ready,
  // receive nibbles
  output logic o_rx_valid,
  output logic [3:0] o_rx_nibble,
  output logic o_rx_err,
  output logic o_carrier,
  output logic o_collision,
  // management requests
  input wire logic i_mgmt_req,
  input wire logic i_mgmt_write,
  input wire logic [2:0] i_mgmt_phy,
  input wire logic [4:0] i_mgmt_reg,
  input wire logic [15:0] i_mgmt_wdata,
  output logic o_mgmt_busy,
  output logic o_mgmt_done,
  output logic [15:0] o_mgmt_rdata,
  // pins
  pmm_mii_if.mac link
);

  // ==========================================================
  // synchronisers for every pin that comes in except ref_clock_out_pin, which is not used
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  logic txc_prev_reg;
  logic rxc_prev_reg;
  logic tx_rise;
  logic rx_rise;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      txc_prev_reg <= 1'b0;
      rxc_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= {link.mdio, link.col, link.crs, link.tx_clk, link.rx_clk,
                    link.rx_er, link.rx_dv, link.rxd}; // R5
      sync2_reg <= sync1_reg;
      txc_prev_reg <= sync2_reg[7];
      rxc_prev_reg <= sync2_reg[6];
    end
  end

  assign tx_rise = sync2_reg[7] && !txc_prev_reg;
  assign rx_rise = sync2_reg[6] && !rxc_prev_reg;
  assign o_carrier = sync2_reg[8]; // R5
  assign o_collision = sync2_reg[9]; // R5

  // ==========================================================
  // data path
  logic [5:0] tx_pins_reg;
  logic [5:0] tx_pins_next;
  logic [5:0] rx_reg;
  logic [5:0] rx_next;

  always_comb begin
    tx_pins_next = tx_pins_reg;
    rx_next = {rx_reg[5:4] & 2'h0, rx_reg[3:0]};
    if (tx_rise) begin
      tx_pins_next = {i_tx_err & i_tx_valid, i_tx_valid, i_tx_nibble}; // R3 R6
    end
    if (rx_rise) begin
      rx_next = {sync2_reg[5] & sync2_reg[4], sync2_reg[4], sync2_reg[3:0]}; // R6
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_pins_reg <= '0;
      rx_reg <= '0;
    end else begin
      tx_pins_reg <= tx_pins_next;
      rx_reg <= rx_next;
    end
  end

  assign link.txd = tx_pins_reg[3:0];
  assign link.tx_en = tx_pins_reg[4];
  assign link.tx_er = tx_pins_reg[5];
  assign o_tx_ready = tx_rise;
  assign o_rx_nibble = rx_reg[3:0];
  assign o_rx_valid = rx_reg[4];
  assign o_rx_err = rx_reg[5];

  // ==========================================================
  // management controller; data changes at the falling edge
  pmm_pkg::pmm_ctl_state_t st_reg;
  pmm_pkg::pmm_ctl_state_t st_next;
  logic [63:0] frame_reg;
  logic [63:0] frame_next;
  logic [6:0] idx_reg;
  logic [6:0] idx_next;
  logic [5:0] div_reg;
  logic [5:0] div_next;
  logic mdc_reg;
  logic mdc_next;
  logic mdo_reg;
  logic mdo_next;
  logic mdoe_reg;
  logic mdoe_next;
  logic rd_op_reg;
  logic rd_op_next;
  logic done_reg;
  logic done_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;

  always_comb begin
    st_next = st_reg;
    frame_next = frame_reg;
    idx_next = idx_reg;
    div_next = div_reg;
    mdc_next = mdc_reg;
    mdo_next = mdo_reg;
    mdoe_next = mdoe_reg;
    rd_op_next = rd_op_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    case (st_reg)
      pmm_pkg::HS_IDLE: begin
        mdc_next = 1'b0;
        if (i_mgmt_req) begin
          frame_next = {pmm_pkg::PREAMBLE, pmm_pkg::START_PAT, // R15
                        i_mgmt_write ? pmm_pkg::OP_WRITE : pmm_pkg::OP_READ,
                        pmm_pkg::ADDR_HIGH, i_mgmt_phy, i_mgmt_reg, // R14
                        pmm_pkg::TA_WRITE, i_mgmt_write ? i_mgmt_wdata : 16'h0000}; // R16
          rd_op_next = !i_mgmt_write;
          idx_next = '0;
          div_next = '0;
          mdo_next = 1'b1;
          mdoe_next = 1'b1; // R11
          st_next = pmm_pkg::HS_RUN;
        end
      end
      pmm_pkg::HS_RUN: begin
        div_next = div_reg + 6'd1;
        if (div_reg == 6'(pmm_pkg::MDC_HALF_CYC - 1)) begin
          div_next = '0;
          mdc_next = !mdc_reg; // R11
          if (!mdc_reg) begin
            if (rd_op_reg && idx_reg >= 7'(pmm_pkg::DATA_FIRST_IDX)) begin
              rdata_next = {rdata_reg[14:0], sync2_reg[10]};
            end
            idx_next = idx_reg + 7'd1;
          end else if (idx_reg == 7'(pmm_pkg::FRAME_BITS)) begin
            mdoe_next = 1'b0;
            done_next = 1'b1;
            st_next = pmm_pkg::HS_IDLE;
          end else begin
            mdo_next = frame_reg[6'(pmm_pkg::FRAME_BITS - 1) - idx_reg[5:0]];
            // release the line from the turnaround on for a read
            mdoe_next = !(rd_op_reg && idx_reg >= 7'(pmm_pkg::TA_FIRST_IDX)); // R16
          end
        end
      end
      default: begin
        st_next = pmm_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= pmm_pkg::HS_IDLE;
      frame_reg <= '0;
      idx_reg <= '0;
      div_reg <= '0;
      mdc_reg <= 1'b0;
      mdo_reg <= 1'b1;
      mdoe_reg <= 1'b0;
      rd_op_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      st_reg <= st_next;
      frame_reg <= frame_next;
      idx_reg <= idx_next;
      div_reg <= div_next;
      mdc_reg <= mdc_next;
      mdo_reg <= mdo_next;
      mdoe_reg <= mdoe_next;
      rd_op_reg <= rd_op_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
    end
  end

  assign link.mdc = mdc_reg;
  assign link.mdio_mac_o = mdo_reg;
  assign link.mdio_mac_oe = mdoe_reg;
  assign o_mgmt_busy = st_reg == pmm_pkg::HS_RUN;
  assign o_mgmt_done = done_reg;
  assign o_mgmt_rdata = rdata_reg;

endmodule : pmm_mac_end

// ==== tb/pmm_link_asserts.sv ====
// Purpose: pin checks between the two ends
// Assumes: line clocks of 5 or 50 cycles
// Notes: speed moves only across a reset
`timescale 1ns/1ns
module pmm_link_asserts (
  // system
  input wire logic i_clk,
  input wire logic i_reset_n,
  // data pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic tx_er,
  input wire logic rx_dv,
  input wire logic [3:0] rxd,
  input wire logic rx_er,
  // management pins
  input wire logic mdc,
  input wire logic mdio_phy_o,
  input wire logic mdio_phy_oe,
  input wire logic mdio_mac_oe,
  input wire logic mdio
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // ========================================
  // cycles since each line clock rose
  logic [7:0] tp_reg;
  logic [7:0] rp_reg;
  logic tv_reg;
  logic rv_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tp_reg <= 8'h00;
      rp_reg <= 8'h00;
      tv_reg <= 1'b0;
      rv_reg <= 1'b0;
    end else begin
      tp_reg <= $rose(tx_clk) ? 8'h00 : tp_reg + 8'h01;
      rp_reg <= $rose(rx_clk) ? 8'h00 : rp_reg + 8'h01;
      tv_reg <= tv_reg | $rose(tx_clk);
      rv_reg <= rv_reg | $rose(rx_clk);
    end
  end
  // ========================================
  // management steps
  sequence s_pre_ones;
    mdio [*8];
  endsequence
  sequence s_tgt_zero;
    !mdio_phy_o && !mdio_mac_oe ##1 (mdio_phy_oe && !mdio) [*8];
  endsequence
  // ========================================
  // assertions
  a_txclk_period: assert property ($rose(tx_clk) && tv_reg |-> tp_reg == 4 || tp_reg == 49)
    else $error("transmit clock period off");
  a_rxclk_period: assert property ($rose(rx_clk) && rv_reg |-> rp_reg == 4 || rp_reg == 49)
    else $error("receive clock period off");
  a_tx_sync: assert property (!$stable({tx_en, txd, tx_er}) |-> tp_reg inside {[1:5]})
    else $error("transmit group moved off its clock");
  a_rx_sync: assert property (!$stable({rx_dv, rxd, rx_er}) |-> !rx_clk)
    else $error("receive group moved while clock high");
  a_one_driver: assert property (!(mdio_phy_oe && mdio_mac_oe))
    else $error("both ends drive the data line");
  a_mdc_half: assert property ($changed(mdc) |=> $stable(mdc) [*8])
    else $error("management clock half period short");
  a_pre_ones: assert property ($rose(mdio_mac_oe) |-> s_pre_ones)
    else $error("frame does not open with ones");
  a_turn_zero: assert property ($rose(mdio_phy_oe) |-> s_tgt_zero)
    else $error("turnaround not a held zero");
  a_idle_high: assert property ($fell(mdio_mac_oe) |-> !mdio_phy_oe ##1 mdio)
    else $error("released line not high");
endmodule : pmm_link_asserts

// ==== tb/phy_mii_and_mgmt_port_tb.sv ====
// Purpose: bench joining the transceiver end and the MAC end
// Assumes: straps move only while reset is held
// Notes: drivers queue notes, monitors compare them
`timescale 1ns/1ns
module phy_mii_and_mgmt_port_tb;
  // ========================================
  // signals
  logic i_clk, i_reset_n, i_ref_clock_out_enable_strap, i_speed_100, i_full_duplex;
  logic i_carrier, i_collision, i_rx_dv, i_rx_err, o_rx_take, o_tx_strobe, o_tx_en, o_tx_err;
  logic o_mgmt_wr, o_mgmt_rd, o_mii_mode, i_tx_valid, i_tx_err, o_tx_ready, o_rx_valid;
  logic o_rx_err, o_carrier, o_collision, i_mgmt_req, i_mgmt_write, o_mgmt_busy, o_mgmt_done;
  logic [2:0] i_mgmt_address_straps, o_mgmt_addr, i_mgmt_phy;
  logic [3:0] i_mode_straps, i_rx_nibble, o_tx_nibble, i_tx_nibble, o_rx_nibble;
  logic [4:0] o_mgmt_reg, i_mgmt_reg;
  logic [15:0] o_mgmt_wdata, i_mgmt_wdata, o_mgmt_rdata;
  // register file stand-in: data tells which register was read
  wire logic [15:0] i_mgmt_rdata = {o_mgmt_reg, 11'h5a3};
  logic [5:0] txq[$], rxq[$];
  logic [20:0] mq[$], rq[$];
  logic [31:0] seed = 32'h0000_2c61, r;
  logic go, rd_op, ts_seen;
  int err_count, checks_done, cyc;
  // ========================================
  // ends and checker
  pmm_mii_if link();
  pmm_phy_end pmm_phy_end_inst (.*);
  pmm_mac_end pmm_mac_end_inst (.*);
  pmm_link_asserts pmm_link_asserts_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .tx_clk(link.tx_clk), .rx_clk(link.rx_clk),
    .tx_en(link.tx_en), .txd(link.txd), .tx_er(link.tx_er), .rx_dv(link.rx_dv),
    .rxd(link.rxd), .rx_er(link.rx_er), .mdc(link.mdc), .mdio_phy_o(link.mdio_phy_o),
    .mdio_phy_oe(link.mdio_phy_oe), .mdio_mac_oe(link.mdio_mac_oe), .mdio(link.mdio)
  );
  // ========================================
  // helpers
  function automatic logic [31:0] xs_next();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs_next
  task automatic cmp_nib(input string what, input logic [5:0] e, input logic [5:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_nib
  task automatic cmp_val(input string what, input logic [20:0] e, input logic [20:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask : cmp_val
  task automatic wrap_up();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  task automatic phase(input logic s, input logic [3:0] m, input logic e, input logic [2:0] a);
    i_reset_n = 1'b0;
    {i_speed_100, i_mode_straps, i_ref_clock_out_enable_strap, i_mgmt_address_straps} = {s, m, e, a};
    repeat (20) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    cmp_val("mode", 21'(m == 4'h1), 21'(o_mii_mode));
    cmp_val("address", 21'(a), 21'(o_mgmt_addr));
    @(posedge i_clk);
    #1 cmp_val("ref clock", 21'(e), 21'(link.ref_clock_out_pin));
    @(negedge i_clk);
  endtask : phase
  task automatic mgmt(input logic w, input logic [2:0] p, input logic [4:0] g, input logic [15:0] d);
    int n;
    n = 0;
    if (w && p == i_mgmt_address_straps) mq.push_back({g, d});
    if (!w) rq.push_back(p == i_mgmt_address_straps ? {5'h00, g, 11'h5a3} : 21'h0_ffff);
    rd_op = !w;
    {i_mgmt_req, i_mgmt_write, i_mgmt_phy, i_mgmt_reg, i_mgmt_wdata} = {1'b1, w, p, g, d};
    do @(negedge i_clk); while (o_mgmt_busy !== 1'b1 && ++n < 9);
    i_mgmt_req = 1'b0;
    do @(posedge i_clk); while (o_mgmt_done !== 1'b1 && ++n < 4000);
    cmp_val("done", 21'h1, 21'(n < 4000));
    @(negedge i_clk);
  endtask : mgmt
  // ========================================
  // clock, traffic, notes, monitor
  always #4 i_clk = ~i_clk;
  always @(negedge i_clk) begin
    r = xs_next();
    i_tx_valid <= go;
    {i_tx_err, i_tx_nibble} <= r[4:0];
    i_rx_dv <= go & r[10];
    {i_rx_err, i_rx_nibble} <= r[9:5];
  end
  always @(posedge i_clk) begin
    if (o_tx_ready && i_tx_valid) txq.push_back({1'b1, i_tx_err, i_tx_nibble});
    if (o_rx_take && i_rx_dv) rxq.push_back({1'b1, i_rx_err, i_rx_nibble});
  end
  always @(posedge i_clk) begin
    if (ts_seen) cmp_nib("transmit", txq.pop_front(), {o_tx_en, o_tx_err, o_tx_nibble});
    if (o_rx_valid) cmp_nib("receive", rxq.pop_front(), {o_rx_valid, o_rx_err, o_rx_nibble});
    if (o_mgmt_wr) cmp_val("write", mq.pop_front(), {o_mgmt_reg, o_mgmt_wdata});
    if (o_mgmt_rd) cmp_val("read reg", 21'(rq[0][15:11]), 21'(o_mgmt_reg));
    if (o_mgmt_done && rd_op) cmp_val("read", rq.pop_front(), 21'(o_mgmt_rdata));
    ts_seen = o_tx_strobe;
    if (++cyc == 40000) begin
      err_count++;
      wrap_up();
    end
  end
  // ========================================
  // main sequence
  initial begin
    i_clk = 1'b0;
    err_count = 0;
    checks_done = 0;
    cyc = 0;
    {go, rd_op, i_carrier, i_collision, i_full_duplex} = 5'h01;
    {i_mgmt_req, i_mgmt_write, i_mgmt_phy, i_mgmt_reg, i_mgmt_wdata} = '0;
    {i_tx_valid, i_tx_err, i_tx_nibble, i_rx_dv, i_rx_err, i_rx_nibble} = '0;
    phase(1'b1, 4'h1, 1'b1, 3'h5);
    go = 1'b1;
    mgmt(1'b1, 3'h5, 5'h1f, 16'hc3a5);
    mgmt(1'b0, 3'h5, 5'h03, 16'h0000);
    mgmt(1'b0, 3'h0, 5'h0c, 16'h0000);
    mgmt(1'b1, 3'h6, 5'h02, 16'h1234);
    {i_full_duplex, i_carrier, i_collision} = 3'h3;
    repeat (8) @(negedge i_clk);
    cmp_val("carrier", 21'h3, 21'({o_carrier, o_collision}));
    i_full_duplex = 1'b1;
    repeat (8) @(negedge i_clk);
    cmp_val("carrier", 21'h2, 21'({o_carrier, o_collision}));
    {go, i_carrier, i_collision} = 3'h0;
    // drain before reset so no note is lost in flight
    repeat (200) @(negedge i_clk);
    phase(1'b0, 4'h2, 1'b0, 3'h0);
    go = 1'b1;
    mgmt(1'b0, 3'h0, 5'h1f, 16'h0000);
    go = 1'b0;
    repeat (200) @(negedge i_clk);
    cmp_val("pending", 21'h0, 21'(txq.size() + rxq.size() + mq.size() + rq.size()));
    wrap_up();
  end
endmodule : phy_mii_and_mgmt_port_tb
